// ---- hw/sbs_map.vh ----
// Register map, field positions and reset values of the sprite blend selector
`ifndef SBS_MAP_VH
`define SBS_MAP_VH

// Byte addresses on the register port
`define SBS_ADDR_BLEND_CTRL 8'h00
`define SBS_ADDR_SPR_CTRL 8'h04
`define SBS_ADDR_STATUS 8'h08
`define SBS_ADDR_FORMAT 8'h0C
// Window bits [7:5] pick a bank of eight registers, [4:2] the entry
`define SBS_BANK_RATIO 3'h1
`define SBS_BANK_PRIO 3'h2

// Blending control register
`define SBS_BIT_SPR_EN 6

// Sprite control register
`define SBS_TEST_HI 13
`define SBS_TEST_LO 12
`define SBS_THR_HI 10
`define SBS_THR_LO 8

// Test select encodings
`define SBS_TEST_PRI_LE 2'h0
`define SBS_TEST_PRI_EQ 2'h1
`define SBS_TEST_PRI_GE 2'h2
`define SBS_TEST_MSB 2'h3

// Reset values
`define SBS_RST_BLEND_CTRL 16'h0000
`define SBS_RST_SPR_CTRL 16'h0000
`define SBS_RST_FORMAT 3'h0
`define SBS_RST_RATIO 5'h00
`define SBS_RST_PRIO 3'h0

// Ratio limits
`define SBS_RATIO_MAX 5'h1F
`define SBS_WEIGHT_FULL 6'h20

`endif

// ---- hw/sbs_top.v ----
// Sprite blend selector: pixel FIFO, blend decision, weighted average, register port
//
// Our own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ns
`include "sbs_map.vh"

module sbs_fifo #(
    parameter W = 48,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire i_clk,
    input wire i_rst_n,
    input wire i_wr_valid,
    output reg o_wr_ready,
    input wire [W-1:0] i_wr_data,
    output reg o_rd_valid,
    input wire i_rd_ready,
    output wire [W-1:0] o_rd_data
);
    reg [W-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;
    reg [AW:0] next_count;
    wire push;
    wire pop;

    assign push = i_wr_valid & o_wr_ready;
    assign pop = o_rd_valid & i_rd_ready;
    assign o_rd_data = mem[rd_ptr];

    function [AW-1:0] ptr_inc;
        input [AW-1:0] p;
        begin
            if (p == DEPTH[AW-1:0] - 1'b1) begin
                ptr_inc = {AW{1'b0}};
            end else begin
                ptr_inc = p + 1'b1;
            end
        end
    endfunction

    always @* begin
        next_count = count;
        if (push & ~pop) begin
            next_count = count + 1'b1;
        end else if (pop & ~push) begin
            next_count = count - 1'b1;
        end
    end

    always @(posedge i_clk) begin
        if (push) begin
            mem[wr_ptr] <= i_wr_data;
        end
    end

    // Full and empty are kept as flags so both handshake outputs leave flip-flops
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
            o_wr_ready <= 1'b0;
            o_rd_valid <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr <= ptr_inc(wr_ptr);
            end
            if (pop) begin
                rd_ptr <= ptr_inc(rd_ptr);
            end
            count <= next_count;
            o_wr_ready <= (next_count != DEPTH[AW:0]);
            o_rd_valid <= (next_count != {(AW+1){1'b0}});
        end
    end
endmodule // sbs_fifo

module sbs_top #(
    parameter FIFO_DEPTH = 8,
    parameter FIFO_AW = 3
) (
    input wire i_sys_clk,
    input wire i_rst_b,
    input wire [7:0] i_addr,
    input wire [15:0] i_wr_data,
    input wire i_wr_stb,
    input wire i_rd_stb,
    output reg [15:0] o_rd_data,
    input wire i_pix_valid,
    output wire o_pix_ready,
    input wire [15:0] i_pix_data,
    input wire i_pix_rgb,
    input wire [15:0] i_pal_color,
    input wire [14:0] i_bg_color,
    output reg o_out_valid,
    input wire i_out_ready,
    output reg [14:0] o_out_color,
    output reg o_out_blended
);
    localparam PW = 48;

    reg [1:0] rst_q;
    wire rst_n;

    reg [15:0] blend_ctrl;
    reg [15:0] spr_ctrl;
    reg [2:0] pix_format;
    reg [4:0] ratio [0:7];
    reg [2:0] prio [0:7];
    reg [15:0] blend_count;

    wire fifo_valid;
    wire fifo_ready;
    wire [PW-1:0] fifo_data;
    wire [15:0] q_data;
    wire q_rgb;
    wire [15:0] q_pal;
    wire [14:0] q_bg;
    wire advance;

    wire [1:0] test_sel;
    wire [2:0] threshold;
    wire spr_en;

    reg [2:0] pri_idx;
    reg [2:0] rat_idx;
    reg fmt_blend_ok;
    reg [2:0] pix_pri;
    reg test_pass;
    reg do_blend;
    reg [4:0] sel_ratio;
    reg [14:0] spr_color;
    reg [14:0] next_color;
    reg [15:0] rd_mux;
    integer i;

    // Reset enters asynchronously but is released through two flops
    always @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_q <= 2'h0;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end
    assign rst_n = rst_q[1];

    sbs_fifo #(
        .W(PW),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_fifo (
        .i_clk(i_sys_clk),
        .i_rst_n(rst_n),
        .i_wr_valid(i_pix_valid),
        .o_wr_ready(fifo_ready),
        .i_wr_data({i_pix_data, i_pix_rgb, i_pal_color, i_bg_color}),
        .o_rd_valid(fifo_valid),
        .i_rd_ready(advance),
        .o_rd_data(fifo_data)
    );
    assign o_pix_ready = fifo_ready;

    assign q_data = fifo_data[47:32];
    assign q_rgb = fifo_data[31];
    assign q_pal = fifo_data[30:15];
    assign q_bg = fifo_data[14:0];

    // The output stage stalls the FIFO, so a held output backs up into the source
    assign advance = fifo_valid & (~o_out_valid | i_out_ready);

    assign spr_en = blend_ctrl[`SBS_BIT_SPR_EN];
    assign test_sel = spr_ctrl[`SBS_TEST_HI:`SBS_TEST_LO];
    assign threshold = spr_ctrl[`SBS_THR_HI:`SBS_THR_LO];

    // Ratio 31 gives the full weight so the background alone shows
    function [4:0] blend_chan;
        input [4:0] s;
        input [4:0] b;
        input [4:0] r;
        reg [5:0] w;
        reg [10:0] acc;
        begin
            w = (r == `SBS_RATIO_MAX) ? `SBS_WEIGHT_FULL : {1'b0, r};
            acc = {5'h00, s} * (`SBS_WEIGHT_FULL - w) + {5'h00, b} * w;
            blend_chan = acc[9:5];
        end
    endfunction

    // Per-format field positions; formats 4 to 7 are 8-bit high-resolution
    always @* begin
        pri_idx = 3'h0;
        rat_idx = 3'h0;
        fmt_blend_ok = 1'b1;
        case (pix_format)
            3'h0: begin
                pri_idx = {1'b0, q_data[15:14]};
                rat_idx = q_data[13:11];
            end
            3'h1: begin
                pri_idx = q_data[15:13];
                rat_idx = {1'b0, q_data[12:11]};
            end
            3'h2: begin
                pri_idx = {2'h0, q_data[15]};
                rat_idx = q_data[14:12];
            end
            3'h3: begin
                pri_idx = {1'b0, q_data[15:14]};
                rat_idx = {2'h0, q_data[13]};
            end
            3'h7: begin
                pri_idx = {2'h0, q_data[7]};
                rat_idx = {2'h0, q_data[6]};
            end
            default: begin
                pri_idx = {1'b0, q_data[7:6]};
                fmt_blend_ok = 1'b0;
            end
        endcase
    end

    // One test, chosen globally, is applied to every pixel
    always @* begin
        pix_pri = q_rgb ? prio[0] : prio[pri_idx];
        case (test_sel)
            `SBS_TEST_PRI_LE: test_pass = (pix_pri <= threshold);
            `SBS_TEST_PRI_EQ: test_pass = (pix_pri == threshold);
            `SBS_TEST_PRI_GE: test_pass = (pix_pri >= threshold);
            `SBS_TEST_MSB: test_pass = q_rgb | q_pal[15];
            default: test_pass = 1'b0;
        endcase
        do_blend = spr_en & test_pass & (q_rgb | fmt_blend_ok);
        if (test_sel == `SBS_TEST_MSB || q_rgb) begin
            sel_ratio = ratio[0];
        end else begin
            sel_ratio = ratio[rat_idx];
        end
        spr_color = q_rgb ? q_data[14:0] : q_pal[14:0];
        if (do_blend) begin
            next_color = {blend_chan(spr_color[14:10], q_bg[14:10], sel_ratio),
                blend_chan(spr_color[9:5], q_bg[9:5], sel_ratio),
                blend_chan(spr_color[4:0], q_bg[4:0], sel_ratio)};
        end else begin
            next_color = spr_color;
        end
    end

    always @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_out_valid <= 1'b0;
            o_out_color <= 15'h0000;
            o_out_blended <= 1'b0;
            blend_count <= 16'h0000;
        end else begin
            if (advance) begin
                o_out_valid <= 1'b1;
                o_out_color <= next_color;
                o_out_blended <= do_blend;
                if (do_blend) begin
                    blend_count <= blend_count + 16'h0001;
                end
            end else if (i_out_ready) begin
                o_out_valid <= 1'b0;
            end
        end
    end

    // Register writes
    always @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            blend_ctrl <= `SBS_RST_BLEND_CTRL;
            spr_ctrl <= `SBS_RST_SPR_CTRL;
            pix_format <= `SBS_RST_FORMAT;
            for (i = 0; i < 8; i = i + 1) begin
                ratio[i] <= `SBS_RST_RATIO;
                prio[i] <= `SBS_RST_PRIO;
            end
        end else if (i_wr_stb) begin
            if (i_addr == `SBS_ADDR_BLEND_CTRL) begin
                blend_ctrl <= i_wr_data;
            end
            if (i_addr == `SBS_ADDR_SPR_CTRL) begin
                spr_ctrl <= i_wr_data;
            end
            if (i_addr == `SBS_ADDR_FORMAT) begin
                pix_format <= i_wr_data[2:0];
            end
            if (i_addr[7:5] == `SBS_BANK_RATIO && i_addr[1:0] == 2'h0) begin
                ratio[i_addr[4:2]] <= i_wr_data[4:0];
            end
            if (i_addr[7:5] == `SBS_BANK_PRIO && i_addr[1:0] == 2'h0) begin
                prio[i_addr[4:2]] <= i_wr_data[2:0];
            end
        end
    end

    // Read mux; unmapped addresses read as zero
    always @* begin
        rd_mux = 16'h0000;
        if (i_addr == `SBS_ADDR_BLEND_CTRL) begin
            rd_mux = blend_ctrl;
        end else if (i_addr == `SBS_ADDR_SPR_CTRL) begin
            rd_mux = spr_ctrl;
        end else if (i_addr == `SBS_ADDR_STATUS) begin
            rd_mux = blend_count;
        end else if (i_addr == `SBS_ADDR_FORMAT) begin
            rd_mux = {13'h0000, pix_format};
        end else if (i_addr[7:5] == `SBS_BANK_RATIO && i_addr[1:0] == 2'h0) begin
            rd_mux = {11'h000, ratio[i_addr[4:2]]};
        end else if (i_addr[7:5] == `SBS_BANK_PRIO && i_addr[1:0] == 2'h0) begin
            rd_mux = {13'h0000, prio[i_addr[4:2]]};
        end
    end

    // Read data stands only in the cycle after the strobe
    always @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_rd_data <= 16'h0000;
        end else if (i_rd_stb) begin
            o_rd_data <= rd_mux;
        end else begin
            o_rd_data <= 16'h0000;
        end
    end
endmodule // sbs_top

// ---- verification/sbs_properties.sv ----
// Port-level checks for the sprite blend selector
`timescale 1ns/1ns
module sbs_properties (
    input wire i_sys_clk,
    input wire i_rst_b,
    input wire [7:0] i_addr,
    input wire [15:0] i_wr_data,
    input wire i_wr_stb,
    input wire i_rd_stb,
    input wire [15:0] o_rd_data,
    input wire o_pix_ready,
    input wire o_out_valid,
    input wire i_out_ready,
    input wire [14:0] o_out_color,
    input wire o_out_blended
);
    reg en;
    reg [15:0] sc;
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_b);
    // Shadows assume config changes only while the pixel path is empty
    always @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            en <= 1'h0;
            sc <= 16'h0000;
        end else if (i_wr_stb && i_addr == 8'h00) begin
            en <= i_wr_data[6];
        end else if (i_wr_stb && i_addr == 8'h04) begin
            sc <= i_wr_data & 16'h3700;
        end
    end
    chk_rd_idle: assert property (!$past(i_rd_stb) |-> o_rd_data == 16'h0000)
        else $error("read data not zero");
    chk_rd_unmapped: assert property (i_rd_stb && i_addr == 8'h10 |=> o_rd_data == 16'h0000)
        else $error("unmapped read not zero");
    chk_ratio_width: assert property (i_rd_stb && i_addr[7:5] == 3'h1 |=> o_rd_data[15:5] == 11'h000)
        else $error("ratio wider than five bits");
    chk_ctrl_read: assert property (i_rd_stb && i_addr == 8'h04 |=> (o_rd_data & 16'h3700) == sc)
        else $error("sprite control readback wrong");
    chk_out_hold: assert property (o_out_valid && !i_out_ready |=>
        o_out_valid && $stable(o_out_color) && $stable(o_out_blended))
        else $error("output changed while stalled");
    chk_blend_en: assert property (o_out_valid && o_out_blended |-> en)
        else $error("blended while disabled");
    chk_rst_ready: assert property ($rose(i_rst_b) |-> !o_pix_ready [*2])
        else $error("ready too early after reset");
    chk_ready_up: assert property ($rose(i_rst_b) |-> ##[2:6] o_pix_ready)
        else $error("ready never rose after reset");
    cover property (o_out_valid && o_out_blended);
    cover property (o_out_valid && !o_out_blended);
    cover property (!o_pix_ready && i_out_ready);
endmodule // sbs_properties

// ---- verification/sbs_pix_model.sv ----
// Sprite pixel source and result sink on the far side of the blender
`timescale 1ns/1ns
module sbs_pix_model (
    input wire logic i_clk,
    input wire logic i_ready,
    input wire logic i_stall,
    input wire logic i_out_valid,
    input wire logic [15:0] i_out,
    output logic o_valid,
    output logic [47:0] o_pix,
    output logic o_out_ready
);
    logic [47:0] src[$];
    logic [15:0] snk[$];
    initial begin
        o_valid = 1'h0;
        o_pix = 48'h0;
        o_out_ready = 1'h1;
    end
    always @(posedge i_clk) begin
        if (o_valid && i_ready) begin
            void'(src.pop_front());
        end
        if (i_out_valid && o_out_ready) begin
            snk.push_back(i_out);
        end
        o_valid <= src.size() > 0;
        // Idle lines flip so a stale pixel never passes for fresh data
        o_pix <= (src.size() > 0) ? src[0] : ~o_pix;
        o_out_ready <= !i_stall;
    end
endmodule // sbs_pix_model

// ---- verification/sbs_top_tb.sv ----
// Self-checking bench for the sprite blend selector
`timescale 1ns/1ns
module sbs_top_tb;
    logic clk = 1'h0;
    logic rst_b = 1'h0;
    logic wstb = 1'h0;
    logic rstb = 1'h0;
    logic stall = 1'h0;
    logic [7:0] addr = 8'h00;
    logic [15:0] wdat = 16'h0000;
    logic [15:0] rdat;
    logic [47:0] pix;
    logic pv, pr, ov, ordy, bl;
    logic [14:0] oc;
    logic [15:0] exq[$];
    int mismatches = 0;
    int checks = 0;
    int t, h, i;
    localparam logic [14:0] BG = 15'h001F;
    localparam logic [11:0] TBL = 12'hED6;
    initial begin
        forever #50 clk = ~clk;
    end
    sbs_top uut (.i_sys_clk(clk), .i_rst_b(rst_b), .i_addr(addr), .i_wr_data(wdat),
        .i_wr_stb(wstb), .i_rd_stb(rstb), .o_rd_data(rdat), .i_pix_valid(pv),
        .o_pix_ready(pr), .i_pix_data(pix[15:0]), .i_pix_rgb(pix[47]),
        .i_pal_color(pix[46:31]), .i_bg_color(pix[30:16]), .o_out_valid(ov),
        .i_out_ready(ordy), .o_out_color(oc), .o_out_blended(bl));
    sbs_pix_model pm (.i_clk(clk), .i_ready(pr), .i_stall(stall), .i_out_valid(ov),
        .i_out({bl, oc}), .o_valid(pv), .o_pix(pix), .o_out_ready(ordy));
    task chk(input string n, input logic [15:0] s, input logic [15:0] e);
        checks++;
        if (s !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task wr(input logic [7:0] a, input logic [15:0] d);
        addr <= a;
        wdat <= d;
        wstb <= 1'h1;
        @(posedge clk);
        wstb <= 1'h0;
        @(posedge clk);
    endtask
    task rd(input logic [7:0] a, input logic [15:0] e);
        addr <= a;
        rstb <= 1'h1;
        @(posedge clk);
        rstb <= 1'h0;
        @(negedge clk);
        chk($sformatf("reg %h", a), rdat, e);
        @(posedge clk);
    endtask
    task cfg(input logic e, input logic [1:0] ts, input logic [2:0] th);
        wr(8'h00, {9'h000, e, 6'h00});
        wr(8'h04, {2'h0, ts, 1'h0, th, 8'h00});
    endtask
    function automatic logic [14:0] mix(input logic [14:0] s, b, input logic [4:0] r);
        logic [5:0] w;
        logic [10:0] c;
        // Ratio 31 must land fully on the background, so it weighs 32
        w = (r == 5'h1F) ? 6'h20 : {1'h0, r};
        for (int k = 0; k < 3; k++) begin
            c = s[k*5+:5] * (6'h20 - w) + b[k*5+:5] * w;
            mix[k*5+:5] = c[9:5];
        end
    endfunction
    task px(input logic rgb, input logic [15:0] pal, d, input logic b, input logic [4:0] r);
        logic [14:0] s;
        s = rgb ? d[14:0] : pal[14:0];
        @(negedge clk);
        pm.src.push_back({rgb, pal, BG, d});
        exq.push_back(b ? {1'h1, mix(s, BG, r)} : {1'h0, s});
        @(posedge clk);
    endtask
    task drain;
        int n;
        for (n = 0; n < 300 && pm.snk.size() < exq.size(); n++) @(posedge clk);
        if (pm.snk.size() < exq.size()) begin
            mismatches++;
            report_and_stop;
        end
        while (exq.size() > 0) chk("pixel", pm.snk.pop_front(), exq.pop_front());
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst_b <= 1'h1;
        repeat (3) @(posedge clk);
        rd(8'h00, 16'h0000);
        rd(8'h04, 16'h0000);
        rd(8'h10, 16'h0000);
        for (i = 0; i < 8; i++) wr(8'h20 + 8'(i * 4), 16'(i * 4 + 3));
        for (i = 0; i < 8; i++) rd(8'h20 + 8'(i * 4), 16'(i * 4 + 3));
        $display("register test done");
        wr(8'h20, 16'h0008);
        wr(8'h40, 16'h0003);
        for (t = 0; t < 4; t++) begin
            for (h = 2; h < 5; h++) begin
                cfg(1'h1, t[1:0], h[2:0]);
                px(1'h1, 16'h0000, 16'h7C00, TBL[t*3+h-2], 5'h08);
                drain;
            end
            rd(8'h04, {2'h0, t[1:0], 1'h0, 3'h4, 8'h00});
        end
        $display("test select done");
        cfg(1'h0, 2'h3, 3'h0);
        px(1'h1, 16'h0000, 16'h7C00, 1'h0, 5'h00);
        drain;
        cfg(1'h1, 2'h3, 3'h0);
        wr(8'h20, 16'h0000);
        px(1'h1, 16'h0000, 16'h1234, 1'h1, 5'h00);
        drain;
        wr(8'h20, 16'h001F);
        px(1'h1, 16'h0000, 16'h1234, 1'h1, 5'h1F);
        drain;
        wr(8'h20, 16'h0008);
        px(1'h0, 16'h0ABC, 16'hA800, 1'h0, 5'h00);
        px(1'h0, 16'h8ABC, 16'hA800, 1'h1, 5'h08);
        drain;
        wr(8'h48, 16'h0005);
        wr(8'h34, 16'h0014);
        cfg(1'h1, 2'h2, 3'h5);
        px(1'h0, 16'h0ABC, 16'hA800, 1'h1, 5'h14);
        drain;
        cfg(1'h1, 2'h2, 3'h0);
        wr(8'h0C, 16'h0001);
        px(1'h0, 16'h0ABC, 16'h3800, 1'h1, 5'h0F);
        drain;
        wr(8'h0C, 16'h0004);
        px(1'h0, 16'h0ABC, 16'h00C0, 1'h0, 5'h00);
        drain;
        $display("pixel path test done");
        rd(8'h08, 16'h000D);
        cfg(1'h0, 2'h0, 3'h0);
        stall <= 1'h1;
        for (t = 0; t < 12; t++) px(1'h1, 16'h0000, 16'(t), 1'h0, 5'h00);
        repeat (20) @(posedge clk);
        // Eight words in the FIFO plus one in the stalled output stage
        chk("held", 16'(pm.src.size()), 16'h0003);
        stall <= 1'h0;
        drain;
        $display("buffer test done");
        report_and_stop;
    end
endmodule // sbs_top_tb
bind sbs_top sbs_properties u_chk (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_addr(i_addr),
    .i_wr_data(i_wr_data), .i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb), .o_rd_data(o_rd_data),
    .o_pix_ready(o_pix_ready), .o_out_valid(o_out_valid), .i_out_ready(i_out_ready),
    .o_out_color(o_out_color), .o_out_blended(o_out_blended));
